/* include/led_spi_pkg.sv */
// Constants and types of the serial register bank of the two-channel LED driver
package led_spi_pkg;

    localparam int CMD_READ_BIT = 15;
    localparam int CMD_ADDR_MSB = 14;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_DATA_MSB = 7;
    localparam logic [3:0] RESP_MSB = 4'hf;
    localparam logic [3:0] BIT_CNT_LAST = 4'hf;
    localparam logic [3:0] BIT_CNT_FIRST = 4'h1;
    localparam logic [3:0] BIT_CNT_FRAME = 4'h0;
    localparam int RESP_ERR_BIT = 14;

    localparam logic [6:0] ADDR_FUNC_CTL = 7'h00;
    localparam logic [6:0] ADDR_GATE_SUPPLY = 7'h01;
    localparam logic [6:0] ADDR_CH1_CURRENT = 7'h02;
    localparam logic [6:0] ADDR_CH2_CURRENT = 7'h03;
    localparam logic [6:0] ADDR_RESERVED_A = 7'h04;
    localparam logic [6:0] ADDR_SCALE_SEL = 7'h05;
    localparam logic [6:0] ADDR_COPY_PULSE = 7'h06;
    localparam logic [6:0] ADDR_CH1_BAND = 7'h0b;
    localparam logic [6:0] ADDR_CH2_BAND = 7'h0c;
    localparam logic [6:0] ADDR_RESERVED_B = 7'h0d;
    localparam logic [6:0] ADDR_SUPPLY_LOW = 7'h0f;
    localparam logic [6:0] ADDR_MEM_CMD = 7'h17;
    localparam logic [6:0] ADDR_MEM_WDATA_LO = 7'h18;
    localparam logic [6:0] ADDR_MEM_WDATA_HI = 7'h19;
    localparam logic [6:0] ADDR_CTL_GROUP_LAST = 7'h1f;
    localparam logic [6:0] ADDR_CH1_VOLT_ON = 7'h20;
    localparam logic [6:0] ADDR_CH1_VOLT_OFF = 7'h21;
    localparam logic [6:0] ADDR_CH2_VOLT_ON = 7'h22;
    localparam logic [6:0] ADDR_CH2_VOLT_OFF = 7'h23;
    localparam logic [6:0] ADDR_RESERVED_C = 7'h24;
    localparam logic [6:0] ADDR_RESERVED_D = 7'h25;
    localparam logic [6:0] ADDR_DIE_TEMP = 7'h26;
    localparam logic [6:0] ADDR_MEM_RDATA_LO = 7'h28;
    localparam logic [6:0] ADDR_MEM_RDATA_HI = 7'h29;
    localparam logic [6:0] ADDR_FALLBACK = 7'h33;
    localparam logic [6:0] ADDR_BOOTSTRAP_FLAGS = 7'h34;
    localparam logic [6:0] ADDR_STRING_FLAGS = 7'h35;
    localparam logic [6:0] ADDR_MEMORY_PWM_FLAGS = 7'h36;
    localparam logic [6:0] ADDR_PRIMARY_FLAGS = 7'h37;
    localparam logic [6:0] ADDR_INPUT_SUPPLY = 7'h38;

    localparam int FUNC_STATUS_BIT = 7;
    localparam int FUNC_CLEAR_BIT = 6;
    localparam int FUNC_CH2_DIM_BIT = 2;
    localparam int FUNC_CH1_DIM_BIT = 1;
    localparam int FALLBACK_STATUS_BIT = 7;
    localparam int MEM_READ_BIT = 7;
    localparam int MEM_WRITE_BIT = 6;
    localparam int MEM_LOC_MSB = 4;

    localparam logic [7:0] BOOTSTRAP_MASK = 8'h03;
    localparam logic [7:0] STRING_MASK = 8'h1b;
    localparam logic [7:0] MEMORY_PWM_MASK = 8'h1b;

    typedef struct packed {
        logic [7:0] funcCtl;
        logic [7:0] gateSupply;
        logic [7:0] ch1Current;
        logic [7:0] ch2Current;
        logic [7:0] reservedA;
        logic [7:0] scaleSel;
        logic [7:0] copyPulse;
        logic [7:0] ch1Band;
        logic [7:0] ch2Band;
        logic [7:0] reservedB;
        logic [7:0] supplyLow;
        logic [7:0] memCmd;
        logic [7:0] memWdataLo;
        logic [7:0] memWdataHi;
        logic [7:0] reservedC;
        logic [7:0] reservedD;
        logic [7:0] fallback;
    } ctl_regs_type;

    localparam ctl_regs_type CTL_RESET = '{
        funcCtl: 8'h0e,
        gateSupply: 8'h96,
        ch1Current: 8'h00,
        ch2Current: 8'h00,
        reservedA: 8'h17,
        scaleSel: 8'h07,
        copyPulse: 8'h00,
        ch1Band: 8'h03,
        ch2Band: 8'h03,
        reservedB: 8'h03,
        supplyLow: 8'hff,
        memCmd: 8'h00,
        memWdataLo: 8'h00,
        memWdataHi: 8'h00,
        reservedC: 8'h00,
        reservedD: 8'h00,
        fallback: 8'h0e
    };

    localparam logic [15:0] RESP_RESET = 16'h0000;
    localparam logic [2:0] SEL_SYNC_RESET = 3'h7;
    localparam logic ACK_TOG_RESET = 1'b1;
    localparam logic SEEN_TOG_RESET = 1'b0;

endpackage : led_spi_pkg

/* logic/led_spi_regbank.sv */
// Serial register bank of the two-channel LED driver, with daisy-chain pass-through
// Overview of operation
// - Read frames ignore shifted-in data byte
// - Shift out status byte and addressed register
// - Bit count not multiple of 16: error
// - Decode seven-bit address space, 128 locations
// - Control below 0x20 and at 0x24, 0x25, 0x33; diagnostics elsewhere from 0x20
// - Diagnostics follow internal monitors, no reset
// - Writing supply reading register sets error
// - Control registers load documented reset values
// - Fallback register: status, exit, timeout, config
// - Primary flags register is default response
// - Memory command, write data, read data registers
// - Latch transfer error as status bit until cleared by a clear-bit write
// - Each chained device runs its own command
// - Command: read bit, address, data byte
// - Response: primary flags, then previous register
// - Sample falling, shift rising, float deselected
// - First response after power-up is zero
`timescale 1ns/1ps
module led_spi_regbank
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic selectLow,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutOen,
    input wire logic supplyStatus,
    input wire logic overtempFlag,
    input wire logic gateSupplyFault,
    input wire logic gateSupplyGood,
    input wire logic ch1CurrentReached,
    input wire logic ch2CurrentReached,
    input wire logic linkModeStatus,
    input wire logic fallbackStatus,
    input wire logic [7:0] ch1VoltOn,
    input wire logic [7:0] ch1VoltOff,
    input wire logic [7:0] ch2VoltOn,
    input wire logic [7:0] ch2VoltOff,
    input wire logic [7:0] dieTemperature,
    input wire logic [7:0] inputSupplyReading,
    input wire logic [7:0] bootstrapFlags,
    input wire logic [7:0] stringFlags,
    input wire logic [7:0] memoryPwmFlags,
    input wire logic [15:0] memoryReadData,
    output logic ch1DimmingCtl,
    output logic ch2DimmingCtl,
    output logic [7:0] gateSupplyCode,
    output logic [7:0] ch1CurrentCode,
    output logic [7:0] ch2CurrentCode,
    output logic [7:0] supplyLowCode,
    output logic [7:0] currentScaleSel,
    output logic [7:0] rangeCopyPulse,
    output logic [7:0] ch1RippleBand,
    output logic [7:0] ch2RippleBand,
    output logic [6:0] fallbackModeCtl,
    output logic memoryReadTrigger,
    output logic memoryWriteTrigger,
    output logic [4:0] memoryLocation,
    output logic [15:0] memoryWriteData,
    output logic memoryFlagsClear
);
    import led_spi_pkg::*;

    typedef struct packed {
        logic [2:0] selSync;
        logic ackTog;
        logic linkErr;
        logic [15:0] resp;
        ctl_regs_type ctl;
        logic memRdPulse;
        logic memWrPulse;
        logic memClrPulse;
    } sys_state_type;

    typedef struct packed {
        logic [15:0] rxShift;
        logic [3:0] bitCnt;
        logic wrapped;
        logic seenTog;
    } rx_state_type;

    typedef struct packed {
        logic txBit;
    } tx_state_type;

    sys_state_type sysQ;
    sys_state_type sysD;
    rx_state_type rxQ;
    rx_state_type rxD;
    tx_state_type txQ;
    tx_state_type txD;

    logic newFrame;
    logic frameDone;
    logic frameValid;
    logic cmdRead;
    logic [6:0] cmdAddr;
    logic [7:0] cmdData;
    logic [7:0] readData;

    // Primary flags byte as it goes out with every response
    function automatic logic [7:0] primaryByte(input logic err);
        primaryByte = {supplyStatus, err, overtempFlag, gateSupplyFault,
                       gateSupplyGood, 1'b0, ch2CurrentReached, ch1CurrentReached};
    endfunction : primaryByte

    function automatic logic [7:0] readReg(input ctl_regs_type c, input logic [6:0] a,
                                           input logic err);
        readReg = 8'h00;
        unique case (a)
            ADDR_FUNC_CTL: readReg = {linkModeStatus, 1'b0, c.funcCtl[5:0]};
            ADDR_GATE_SUPPLY: readReg = c.gateSupply;
            ADDR_CH1_CURRENT: readReg = c.ch1Current;
            ADDR_CH2_CURRENT: readReg = c.ch2Current;
            ADDR_RESERVED_A: readReg = c.reservedA;
            ADDR_SCALE_SEL: readReg = c.scaleSel;
            ADDR_COPY_PULSE: readReg = c.copyPulse;
            ADDR_CH1_BAND: readReg = c.ch1Band;
            ADDR_CH2_BAND: readReg = c.ch2Band;
            ADDR_RESERVED_B: readReg = c.reservedB;
            ADDR_SUPPLY_LOW: readReg = c.supplyLow;
            ADDR_MEM_CMD: readReg = c.memCmd;
            ADDR_MEM_WDATA_LO: readReg = c.memWdataLo;
            ADDR_MEM_WDATA_HI: readReg = c.memWdataHi;
            ADDR_CH1_VOLT_ON: readReg = ch1VoltOn;
            ADDR_CH1_VOLT_OFF: readReg = ch1VoltOff;
            ADDR_CH2_VOLT_ON: readReg = ch2VoltOn;
            ADDR_CH2_VOLT_OFF: readReg = ch2VoltOff;
            ADDR_RESERVED_C: readReg = c.reservedC;
            ADDR_RESERVED_D: readReg = c.reservedD;
            ADDR_DIE_TEMP: readReg = dieTemperature;
            ADDR_MEM_RDATA_LO: readReg = memoryReadData[7:0];
            ADDR_MEM_RDATA_HI: readReg = memoryReadData[15:8];
            ADDR_FALLBACK: readReg = {fallbackStatus, c.fallback[6:0]};
            ADDR_BOOTSTRAP_FLAGS: readReg = bootstrapFlags & BOOTSTRAP_MASK;
            ADDR_STRING_FLAGS: readReg = stringFlags & STRING_MASK;
            ADDR_MEMORY_PWM_FLAGS: readReg = memoryPwmFlags & MEMORY_PWM_MASK;
            ADDR_PRIMARY_FLAGS: readReg = primaryByte(err);
            ADDR_INPUT_SUPPLY: readReg = inputSupplyReading;
            default: readReg = 8'h00;
        endcase
    endfunction : readReg

    function automatic ctl_regs_type writeReg(input ctl_regs_type c, input logic [6:0] a,
                                              input logic [7:0] v);
        writeReg = c;
        unique case (a)
            ADDR_FUNC_CTL: writeReg.funcCtl = {1'b0, 1'b0, v[5:0]};
            ADDR_GATE_SUPPLY: writeReg.gateSupply = v;
            ADDR_CH1_CURRENT: writeReg.ch1Current = v;
            ADDR_CH2_CURRENT: writeReg.ch2Current = v;
            ADDR_RESERVED_A: writeReg.reservedA = v;
            ADDR_SCALE_SEL: writeReg.scaleSel = v;
            ADDR_COPY_PULSE: writeReg.copyPulse = v;
            ADDR_CH1_BAND: writeReg.ch1Band = v;
            ADDR_CH2_BAND: writeReg.ch2Band = v;
            ADDR_RESERVED_B: writeReg.reservedB = v;
            ADDR_SUPPLY_LOW: writeReg.supplyLow = v;
            ADDR_MEM_CMD: writeReg.memCmd = v;
            ADDR_MEM_WDATA_LO: writeReg.memWdataLo = v;
            ADDR_MEM_WDATA_HI: writeReg.memWdataHi = v;
            ADDR_RESERVED_C: writeReg.reservedC = v;
            ADDR_RESERVED_D: writeReg.reservedD = v;
            ADDR_FALLBACK: writeReg.fallback = {1'b0, v[6:0]};
            default: writeReg = c;
        endcase
    endfunction : writeReg

    function automatic logic isMapped(input logic [6:0] a);
        isMapped = (writeReg(CTL_RESET, a, 8'h5a) != CTL_RESET);
    endfunction : isMapped

    // Link domain, falling edge: sample the input and count bits
    // A new frame is recognised on its first falling edge, when the toggle from the
    // system side differs from the copy taken at the previous frame's first edge.
    assign newFrame = (rxQ.seenTog != sysQ.ackTog);

    always_comb
    begin
        rxD = rxQ;
        rxD.rxShift = {rxQ.rxShift[14:0], serialIn};
        if (newFrame)
        begin
            rxD.bitCnt = BIT_CNT_FIRST;
            rxD.wrapped = 1'b0;
            rxD.seenTog = sysQ.ackTog;
        end
        else
        begin
            rxD.bitCnt = rxQ.bitCnt + BIT_CNT_FIRST;
            if (rxQ.bitCnt == BIT_CNT_LAST)
            begin
                rxD.wrapped = 1'b1;
            end
        end
    end

    // The link clock stands still between frames, so its reset cannot wait for an edge
    always_ff @(negedge linkClk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rxQ <= '{rxShift: 16'h0000, bitCnt: BIT_CNT_FRAME, wrapped: 1'b0,
                     seenTog: SEEN_TOG_RESET};
        end
        else
        begin
            rxQ <= rxD;
        end
    end

    // Link domain, rising edge: first sixteen bits are the response, then the input delayed
    always_comb
    begin
        txD = txQ;
        if (rxQ.wrapped)
        begin
            txD.txBit = rxQ.rxShift[15];
        end
        else
        begin
            txD.txBit = sysQ.resp[RESP_MSB - rxQ.bitCnt];
        end
    end

    always_ff @(posedge linkClk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            txQ <= '{txBit: 1'b0};
        end
        else
        begin
            txQ <= txD;
        end
    end

    assign serialOut = newFrame ? sysQ.resp[RESP_MSB] : txQ.txBit;
    assign serialOutOen = selectLow;

    // System domain: execute the frame after select rises
    assign frameDone = sysQ.selSync[1] & ~sysQ.selSync[2];
    assign frameValid = !newFrame && (rxQ.bitCnt == BIT_CNT_FRAME);
    assign cmdRead = rxQ.rxShift[CMD_READ_BIT];
    assign cmdAddr = rxQ.rxShift[CMD_ADDR_MSB:CMD_ADDR_LSB];
    assign cmdData = rxQ.rxShift[CMD_DATA_MSB:0];
    assign readData = readReg(sysQ.ctl, cmdAddr, sysQ.linkErr);

    always_comb
    begin
        logic errSet;
        logic errClr;
        logic doWrite;
        errSet = 1'b0;
        errClr = 1'b0;
        doWrite = 1'b0;
        sysD = sysQ;
        sysD.selSync = {sysQ.selSync[1:0], selectLow};
        sysD.memRdPulse = 1'b0;
        sysD.memWrPulse = 1'b0;
        sysD.memClrPulse = 1'b0;
        if (frameDone)
        begin
            if (!newFrame)
            begin
                sysD.ackTog = ~sysQ.ackTog;
            end
            if (!frameValid)
            begin
                errSet = 1'b1;
            end
            else if (!cmdRead)
            begin
                if (cmdAddr == ADDR_INPUT_SUPPLY)
                begin
                    errSet = 1'b1;
                end
                else
                begin
                    doWrite = 1'b1;
                end
            end
            if (doWrite)
            begin
                sysD.ctl = writeReg(sysQ.ctl, cmdAddr, cmdData);
                errClr = (cmdAddr == ADDR_FUNC_CTL) && cmdData[FUNC_CLEAR_BIT];
                sysD.memRdPulse = (cmdAddr == ADDR_MEM_CMD) && cmdData[MEM_READ_BIT];
                sysD.memWrPulse = (cmdAddr == ADDR_MEM_CMD) && cmdData[MEM_WRITE_BIT];
                sysD.memClrPulse = (cmdAddr == ADDR_MEMORY_PWM_FLAGS);
            end
            sysD.linkErr = errSet | (sysQ.linkErr & ~errClr);
            if (frameValid)
            begin
                sysD.resp = {primaryByte(sysD.linkErr),
                             readReg(sysD.ctl, cmdAddr, sysD.linkErr)};
            end
            else
            begin
                sysD.resp = {primaryByte(sysD.linkErr), sysQ.resp[7:0]};
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sysQ <= '{selSync: SEL_SYNC_RESET, ackTog: ACK_TOG_RESET, linkErr: 1'b0,
                      resp: RESP_RESET, ctl: CTL_RESET, memRdPulse: 1'b0,
                      memWrPulse: 1'b0, memClrPulse: 1'b0};
        end
        else
        begin
            sysQ <= sysD;
        end
    end

    assign ch1DimmingCtl = sysQ.ctl.funcCtl[FUNC_CH1_DIM_BIT];
    assign ch2DimmingCtl = sysQ.ctl.funcCtl[FUNC_CH2_DIM_BIT];
    assign gateSupplyCode = sysQ.ctl.gateSupply;
    assign ch1CurrentCode = sysQ.ctl.ch1Current;
    assign ch2CurrentCode = sysQ.ctl.ch2Current;
    assign supplyLowCode = sysQ.ctl.supplyLow;
    assign currentScaleSel = sysQ.ctl.scaleSel;
    assign rangeCopyPulse = sysQ.ctl.copyPulse;
    assign ch1RippleBand = sysQ.ctl.ch1Band;
    assign ch2RippleBand = sysQ.ctl.ch2Band;
    assign fallbackModeCtl = sysQ.ctl.fallback[6:0];
    assign memoryReadTrigger = sysQ.memRdPulse;
    assign memoryWriteTrigger = sysQ.memWrPulse;
    assign memoryLocation = sysQ.ctl.memCmd[MEM_LOC_MSB:0];
    assign memoryWriteData = {sysQ.ctl.memWdataHi, sysQ.ctl.memWdataLo};
    assign memoryFlagsClear = sysQ.memClrPulse;

    sequence validCmdSeq;
        frameDone && frameValid;
    endsequence

    sequence validWriteSeq(logic [6:0] a);
        validCmdSeq ##0 (!cmdRead && cmdAddr == a);
    endsequence

    badLength_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        frameDone && !frameValid |=> sysQ.linkErr && $stable(sysQ.ctl))
        else $error("bad frame length did not raise error");

    readKeeps_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        validCmdSeq ##0 cmdRead |=> $stable(sysQ.ctl))
        else $error("read frame changed a register");

    supplyWriteErr_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        validWriteSeq(ADDR_INPUT_SUPPLY) |=> sysQ.linkErr)
        else $error("write to supply reading did not raise error");

    readResponse_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        validCmdSeq ##0 cmdRead |=> sysQ.resp[7:0] == $past(readData))
        else $error("response low byte is not the read register");

    statusByte_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        frameDone |=> sysQ.resp[RESP_ERR_BIT] == sysQ.linkErr)
        else $error("response status byte error bit mismatch");

    resetLoad_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        $past(sys_rst) |-> sysQ.ctl == CTL_RESET)
        else $error("control registers not at reset values");

    firstResp_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        $past(sys_rst) |-> sysQ.resp == RESP_RESET ##1 $stable(sysQ.resp) || frameDone)
        else $error("first response after reset is not zero");

    writeTakes_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        validWriteSeq(ADDR_CH1_CURRENT) |=> ch1CurrentCode == $past(cmdData))
        else $error("write data not stored");

    unmappedWrite_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        validCmdSeq ##0 (!cmdRead && !isMapped(cmdAddr)) |=> $stable(sysQ.ctl))
        else $error("write to unmapped address changed a register");

    errorHolds_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        sysQ.linkErr && !frameDone |=> sysQ.linkErr)
        else $error("error flag dropped without a frame");

    daisyPass_a:
    assert property (@(negedge linkClk) disable iff (sys_rst)
        !newFrame && rxQ.wrapped |-> serialOut == $past(serialIn, 16))
        else $error("daisy chain bit not passed on");

endmodule : led_spi_regbank

/* test/spi_master_model.sv */
// Serial master model that shifts command frames into the register bank
`timescale 1ns/1ps
module spi_master_model
(
    output logic linkClk,
    output logic selectLow,
    output logic serialIn,
    input wire logic serialOut
);
    initial
    begin
        linkClk = 1'b0;
        selectLow = 1'b1;
        serialIn = 1'b1;
    end

    // Clock runs only inside the frame; data goes out MSB first
    task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        #7;
        selectLow = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            #24 linkClk = 1'b1;
            // Data moves on the rising edge, clear of the falling sample edge
            serialIn = tx[i];
            #24 rx = {rx[30:0], serialOut};
            linkClk = 1'b0;
        end
        #24 selectLow = 1'b1;
        serialIn = ~serialIn;
        #200;
    endtask : frame
endmodule : spi_master_model

/* test/led_spi_regbank_bench.sv */
// Self-checking bench of the serial register bank
`timescale 1ns/1ps
module led_spi_regbank_bench;
    import led_spi_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b0;
    logic linkClk, selectLow, serialIn, serialOut, serialOutOen;
    logic [5:0] flags = 6'h00;
    logic [7:0] mon [0:5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    logic [7:0] diagIn = 8'hff;
    logic [1:0] modeIn = 2'h0;
    logic [7:0] ch2Code, lowCode, scaleCode, copyCode, band1, band2;
    logic dim1, dim2, flagsClr;
    logic clrSeen = 1'b0;
    logic [15:0] memRd = 16'hbeef;
    logic [7:0] ch1Code, gateCode;
    logic [6:0] fbCtl;
    logic [4:0] memLoc;
    logic [15:0] memWd;
    logic rdTrig, wrTrig;
    logic rdSeen = 1'b0;
    logic wrSeen = 1'b0;
    logic [31:0] rx;
    int error_cnt = 0;
    int check_count = 0;

    always #10 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        if (rdTrig === 1'b1)
            rdSeen <= 1'b1;
        if (wrTrig === 1'b1)
            wrSeen <= 1'b1;
        if (flagsClr === 1'b1)
            clrSeen <= 1'b1;
    end

    spi_master_model u_master (.linkClk(linkClk), .selectLow(selectLow),
        .serialIn(serialIn), .serialOut(serialOut));

    led_spi_regbank u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .linkClk(linkClk),
        .selectLow(selectLow), .serialIn(serialIn), .serialOut(serialOut),
        .serialOutOen(serialOutOen), .supplyStatus(flags[5]), .overtempFlag(flags[4]),
        .gateSupplyFault(flags[3]), .gateSupplyGood(flags[2]), .ch2CurrentReached(flags[1]),
        .ch1CurrentReached(flags[0]), .linkModeStatus(modeIn[0]), .fallbackStatus(modeIn[1]),
        .ch1VoltOn(mon[0]), .ch1VoltOff(mon[1]), .ch2VoltOn(mon[2]), .ch2VoltOff(mon[3]),
        .dieTemperature(mon[4]), .inputSupplyReading(mon[5]), .bootstrapFlags(diagIn),
        .stringFlags(diagIn), .memoryPwmFlags(diagIn), .memoryReadData(memRd),
        .ch1DimmingCtl(dim1), .ch2DimmingCtl(dim2), .gateSupplyCode(gateCode),
        .ch1CurrentCode(ch1Code), .ch2CurrentCode(ch2Code), .supplyLowCode(lowCode),
        .currentScaleSel(scaleCode), .rangeCopyPulse(copyCode), .ch1RippleBand(band1),
        .ch2RippleBand(band2), .fallbackModeCtl(fbCtl), .memoryReadTrigger(rdTrig),
        .memoryWriteTrigger(wrTrig), .memoryLocation(memLoc), .memoryWriteData(memWd),
        .memoryFlagsClear(flagsClr));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cmd(input logic [15:0] c);
        u_master.frame(16, {16'h0000, c}, rx);
    endtask : cmd

    // Reads a list back to back; each answer arrives one frame later
    task automatic reads(input logic [6:0] a[$], input logic [7:0] e[$], input logic [7:0] hi);
        cmd({1'b1, a[0], 8'h00});
        for (int i = 1; i <= a.size(); i++)
        begin
            cmd({1'b1, (i < a.size()) ? a[i] : a[0], 8'h00});
            chk("read word", {hi, e[i - 1]}, rx[15:0]);
        end
    endtask : reads

    task automatic t_reset;
        cmd({1'b1, ADDR_PRIMARY_FLAGS, 8'h00});
        chk("first word", 16'h0000, rx[15:0]);
        chk("idle enable", 16'h0001, {15'h0000, serialOutOen});
        reads('{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h0b, 7'h0c, 7'h0d, 7'h0f,
            7'h17, 7'h18, 7'h19, 7'h24, 7'h25, 7'h33}, '{8'h0e, 8'h96, 8'h00, 8'h00, 8'h17,
            8'h07, 8'h00, 8'h03, 8'h03, 8'h03, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h0e}, 8'h00);
        chk("gate code", 16'h0096, {8'h00, gateCode});
        chk("codes", 16'h00ff, {ch2Code, lowCode});
        chk("scale copy", 16'h0700, {scaleCode, copyCode});
        chk("bands", 16'h0303, {band1, band2});
        chk("dimming", 16'h0003, {14'h0000, dim2, dim1});
        chk("fallback field", 16'h000e, {9'h000, fbCtl});
    endtask : t_reset

    task automatic t_write;
        cmd({1'b0, ADDR_CH1_CURRENT, 8'h5a});
        cmd({1'b1, ADDR_CH1_CURRENT, 8'ha5});
        chk("written word", 16'h005a, rx[15:0]);
        cmd({1'b1, ADDR_CH1_CURRENT, 8'h00});
        chk("read ignores data", 16'h005a, rx[15:0]);
        chk("current code", 16'h005a, {8'h00, ch1Code});
        cmd({1'b0, 7'h10, 8'hc3});
    endtask : t_write

    task automatic t_diag;
        @(posedge sys_clk) flags <= 6'h2d;
        reads('{7'h20, 7'h21, 7'h22, 7'h23, 7'h26, 7'h38, 7'h34, 7'h35, 7'h36, 7'h28, 7'h29,
            7'h37, 7'h7f, 7'h10}, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h03, 8'h1b,
            8'h1b, 8'hef, 8'hbe, 8'h99, 8'h00, 8'h00}, 8'h99);
    endtask : t_diag

    task automatic t_error;
        u_master.frame(15, {17'h00000, ADDR_CH2_CURRENT, 8'h77}, rx);
        reads('{ADDR_CH2_CURRENT}, '{8'h00}, 8'hd9);
        cmd({1'b0, ADDR_FUNC_CTL, 8'h40});
        reads('{ADDR_PRIMARY_FLAGS}, '{8'h99}, 8'h99);
        cmd({1'b0, ADDR_INPUT_SUPPLY, 8'h12});
        reads('{ADDR_INPUT_SUPPLY}, '{8'h66}, 8'hd9);
        cmd({1'b0, ADDR_FUNC_CTL, 8'h40});
    endtask : t_error

    task automatic t_chain;
        u_master.frame(32, {16'h8123, 1'b0, ADDR_CH2_CURRENT, 8'h3c}, rx);
        chk("passed through", 16'h8123, rx[15:0]);
        chk("chain reply", 16'h9900, rx[31:16]);
        reads('{ADDR_CH2_CURRENT}, '{8'h3c}, 8'h99);
    endtask : t_chain

    task automatic t_memory;
        cmd({1'b0, ADDR_MEM_WDATA_LO, 8'h34});
        cmd({1'b0, ADDR_MEM_WDATA_HI, 8'h12});
        cmd({1'b0, ADDR_MEM_CMD, 8'hc5});
        cmd({1'b0, ADDR_FALLBACK, 8'hff});
        cmd({1'b0, ADDR_MEMORY_PWM_FLAGS, 8'h00});
        chk("triggers", 16'h0007, {13'h0000, clrSeen, rdSeen, wrSeen});
        chk("location", 16'h0005, {11'h000, memLoc});
        chk("write data", 16'h1234, memWd);
        chk("fallback field", 16'h007f, {9'h000, fbCtl});
        @(posedge sys_clk) modeIn <= 2'h3;
        reads('{ADDR_FALLBACK, ADDR_FUNC_CTL}, '{8'hff, 8'h80}, 8'h99);
    endtask : t_memory

    task automatic end_sim;
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    initial
    begin
        // Raised by an update so the link-side flops see a reset edge
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        t_reset();
        t_write();
        t_diag();
        t_error();
        t_chain();
        t_memory();
        end_sim();
    end

    initial
    begin
        #400000;
        error_cnt++;
        end_sim();
    end
endmodule : led_spi_regbank_bench
